//--- rtl/clp_switch.sv
// cold load threshold switch: sequencer, registers and raised set
// Summary of operation
// (RULE_01) raised thresholds only while the on/off enable is on.
// (RULE_02) breaker source: open breaker contact means de-energized.
// (RULE_03) current source: no current flow means de-energized.
// (RULE_04) raised set only after the full arming delay de-energized.
// (RULE_05) re-energizing starts the active-hold timer.
// (RULE_06) active-hold expiry restores the normal set.
// (RULE_07) re-energizing below normal pickups starts the quiet timer too.
// (RULE_08) quiet timer defeated by infinite setting or block input.
// (RULE_09) restore waits until a picked-up element drops out.
// (RULE_10) block clears all timers and restores the normal set.
// (RULE_11) block during fault on raised set restarts element timers.
// (RULE_12) power-up with open breaker arms on the normal set.
// (RULE_13) feature works only when configured present.
// (RULE_14) separate raised phase set: two stages and inverse element.
// (RULE_15) separate raised ground set: two stages and inverse element.
// (RULE_16) raised set is apart from the four normal groups.
// (RULE_17) arming delay 0 to 21600 s, default 3600 s.
// (RULE_18) active-hold delay 1 to 21600 s, default 3600 s.
// (RULE_19) detection source defaults to current absence.
// (RULE_20) on/off enable defaults to off.
// (RULE_21) timers count seconds from a one-second tick, reset clears.
// (RULE_22) status output shows when the raised set is in effect.
`timescale 1ns/1ns
module clp_switch
  import clp_pkg::*;
#(
  parameter int P_TICK_CYCLES = TICK_CYCLES
) (
  input  wire logic          i_clk_sys,
  input  wire logic          i_arst_n,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [DW-1:0] i_wdata,
  input  wire logic          i_wr,
  input  wire logic          i_rd,
  output logic      [DW-1:0] o_rdata,
  input  wire logic          i_brk_closed,
  input  wire logic          i_cur_flow,
  input  wire logic          i_below_normal,
  input  wire logic          i_block,
  input  wire logic          i_stop_block,
  input  wire logic          i_elem_pickup,
  input  wire logic [3:0]    i_elem_idx,
  output logic      [DW-1:0] o_elem_param,
  output logic               o_raised_active,
  output logic               o_elem_restart
);
  localparam int CW = $clog2(P_TICK_CYCLES);

  // map a register address onto the raised-set index
  function automatic logic [4:0] param_idx(input logic [AW-1:0] a);
    logic [AW-1:0] dp;
    logic [AW-1:0] dg;
    dp = a - A_PHASE_BASE;
    dg = a - A_GROUND_BASE;
    if (dp < AW'(N_PER_SET)) begin
      param_idx = {1'b1, dp[3:0]};
    end else if (dg < AW'(N_PER_SET)) begin
      param_idx = {1'b1, dg[3:0] + GROUND_IDX0};
    end else begin
      param_idx = 5'h00;
    end
  endfunction

  // keep a time setting inside its range
  function automatic logic [TW-1:0] clamp(input logic [DW-1:0] v,
                                          input logic [TW-1:0] lo,
                                          input logic [TW-1:0] hi);
    if (v > DW'(hi)) begin
      clamp = hi;
    end else if (v < DW'(lo)) begin
      clamp = lo;
    end else begin
      clamp = v[TW-1:0];
    end
  endfunction

  logic          present_q, enable_q, source_q;
  logic [TW-1:0] arming_q, active_q, stop_q;
  logic          brk_s1_q, brk_s2_q, blk_s1_q, blk_s2_q;
  logic          stb_s1_q, stb_s2_q, blk_d_q;
  logic [CW-1:0] tick_cnt_q;
  logic          tick;
  clp_state_e    state_q, state_d;
  logic [TW-1:0] arm_cnt_q, act_cnt_q, stop_cnt_q;
  logic          stop_run_q;
  logic          rd_mem_q, restart_q;
  logic [DW-1:0] rd_reg_q, rd_reg_d, mem_rdata;
  logic [4:0]    widx, ridx;

  // breaker, block and stop-block pins pass two flops; the other pins are used as they come
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {brk_s1_q, brk_s2_q} <= 2'h0;
      {blk_s1_q, blk_s2_q} <= 2'h0;
      {stb_s1_q, stb_s2_q} <= 2'h0;
    end else begin
      {brk_s1_q, brk_s2_q} <= {i_brk_closed, brk_s1_q};
      {blk_s1_q, blk_s2_q} <= {i_block, blk_s1_q};
      {stb_s1_q, stb_s2_q} <= {i_stop_block, stb_s1_q};
    end
  end

  // one-second tick from the system clock
  assign tick = (tick_cnt_q == CW'(P_TICK_CYCLES - 1)); // RULE_21
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
    end
  end

  // decode of conditions
  wire feat_on = present_q & enable_q; // RULE_01 RULE_13
  wire blk = blk_s2_q;
  wire deen = source_q ? !brk_s2_q : !i_cur_flow; // RULE_02 RULE_03
  wire arm_done = (arm_cnt_q >= arming_q); // RULE_04
  wire act_done = (act_cnt_q >= active_q); // RULE_06
  wire stop_off = (stop_q == '0) | stb_s2_q; // RULE_08
  wire stop_done = stop_run_q & !stop_off & (stop_cnt_q >= stop_q);
  wire expire = act_done | stop_done; // RULE_07
  wire raised = (state_q == CLP_ARMED) | (state_q == CLP_ACTIVE)
              | (state_q == CLP_HOLD);
  wire run_ok = feat_on & !blk;

  // sequencer; power-up lands in idle so arming runs on the normal set
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      CLP_IDLE: begin
        if (deen) state_d = CLP_ARMING; // RULE_12
      end
      CLP_ARMING: begin
        if (!deen) state_d = CLP_IDLE;
        else if (arm_done) state_d = CLP_ARMED; // RULE_04
      end
      CLP_ARMED: begin
        if (!deen) state_d = CLP_ACTIVE; // RULE_05
      end
      CLP_ACTIVE: begin
        if (deen) state_d = CLP_ARMED;
        else if (expire) state_d = i_elem_pickup ? CLP_HOLD
                                                 : CLP_IDLE; // RULE_09
      end
      CLP_HOLD: begin
        if (!i_elem_pickup) state_d = CLP_IDLE; // RULE_09
      end
      default: state_d = CLP_IDLE;
    endcase
    if (!run_ok) state_d = CLP_IDLE; // RULE_01 RULE_10 RULE_13
  end

  // timers: counters cleared on entry, block and disable
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= CLP_IDLE;
      arm_cnt_q <= '0;
      act_cnt_q <= '0;
      stop_cnt_q <= '0;
      stop_run_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_d != CLP_ARMING || state_q != CLP_ARMING) begin
        arm_cnt_q <= '0; // RULE_10
      end else if (tick && !arm_done) begin
        arm_cnt_q <= arm_cnt_q + 1'b1; // RULE_21
      end
      if (state_d != CLP_ACTIVE || state_q != CLP_ACTIVE) begin
        act_cnt_q <= '0; // RULE_05 RULE_10
        stop_cnt_q <= '0;
        stop_run_q <= (state_d == CLP_ACTIVE) & i_below_normal; // RULE_07
      end else if (tick) begin
        if (!act_done) act_cnt_q <= act_cnt_q + 1'b1;
        if (stop_cnt_q != MAX_STOP) stop_cnt_q <= stop_cnt_q + 1'b1;
      end
    end
  end

  // element timers restart on block during a fault on the raised set
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      blk_d_q <= 1'b0;
      restart_q <= 1'b0;
    end else begin
      blk_d_q <= blk;
      restart_q <= blk & !blk_d_q & raised & i_elem_pickup; // RULE_11
    end
  end
  assign o_elem_restart = restart_q;
  assign o_raised_active = raised; // RULE_22

  // register writes; time settings are clamped to their ranges
  assign widx = param_idx(i_addr);
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      present_q <= RST_PRESENT;
      enable_q <= RST_ENABLE; // RULE_20
      source_q <= RST_SOURCE; // RULE_19
      arming_q <= RST_ARMING; // RULE_17
      active_q <= RST_ACTIVE; // RULE_18
      stop_q <= RST_STOP;
    end else if (i_wr) begin
      if (i_addr == A_PRESENT) present_q <= i_wdata[F_BIT0];
      if (i_addr == A_ENABLE) enable_q <= i_wdata[F_BIT0];
      if (i_addr == A_SOURCE) source_q <= i_wdata[F_BIT0];
      if (i_addr == A_ARMING) begin
        arming_q <= clamp(i_wdata, '0, MAX_ARMING); // RULE_17
      end
      if (i_addr == A_ACTIVE) begin
        active_q <= clamp(i_wdata, MIN_ACTIVE, MAX_ACTIVE); // RULE_18
      end
      if (i_addr == A_STOP) stop_q <= clamp(i_wdata, '0, MAX_STOP);
    end
  end

  // raised set lives apart from the normal groups
  clp_param_mem u_mem (
    .i_clk_sys (i_clk_sys),
    .i_arst_n  (i_arst_n),
    .i_we      (i_wr & widx[4]), // RULE_14 RULE_15 RULE_16
    .i_waddr   (widx[3:0]),
    .i_wdata   (i_wdata),
    .i_raddr_a (ridx[3:0]),
    .o_rdata_a (mem_rdata),
    .i_raddr_b (i_elem_idx),
    .o_rdata_b (o_elem_param)
  );

  // read decode; unmapped addresses read as zero
  assign ridx = param_idx(i_addr);
  always_comb begin
    rd_reg_d = '0;
    if (i_rd) begin
      unique case (i_addr)
        A_PRESENT: rd_reg_d[F_BIT0] = present_q;
        A_ENABLE:  rd_reg_d[F_BIT0] = enable_q;
        A_SOURCE:  rd_reg_d[F_BIT0] = source_q;
        A_ARMING:  rd_reg_d = DW'(arming_q);
        A_ACTIVE:  rd_reg_d = DW'(active_q);
        A_STOP:    rd_reg_d = DW'(stop_q);
        A_STATUS: begin
          rd_reg_d[F_STAT_RAISED] = raised;
          rd_reg_d[F_STAT_STATE +: 3] = state_q;
          rd_reg_d[F_STAT_DEEN] = deen;
          rd_reg_d[F_STAT_ON] = feat_on;
        end
        default:   rd_reg_d = '0;
      endcase
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_reg_q <= '0;
      rd_mem_q <= 1'b0;
    end else begin
      rd_reg_q <= rd_reg_d;
      rd_mem_q <= i_rd & ridx[4];
    end
  end
  assign o_rdata = rd_mem_q ? mem_rdata : rd_reg_q;

  // checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  sequence s_armed_ok;
    state_q == CLP_ARMED && run_ok;
  endsequence
  sequence s_reenergize;
    !deen ##1 state_q == CLP_ACTIVE && act_cnt_q == '0;
  endsequence

  AST_OFF_NORMAL: assert property (!feat_on |=> !o_raised_active) // RULE_01
    else $error("raised set while feature off");
  AST_BRK_DEEN: assert property (run_ok && source_q && !brk_s2_q // RULE_02
      && state_q == CLP_IDLE |=> state_q == CLP_ARMING)
    else $error("open breaker did not start arming");
  AST_CUR_DEEN: assert property (run_ok && !source_q && !i_cur_flow // RULE_03
      && state_q == CLP_IDLE |=> state_q == CLP_ARMING)
    else $error("no current did not start arming");
  AST_ARM_WAIT: assert property (state_q == CLP_ARMING // RULE_04
      && arm_cnt_q < arming_q |=> !o_raised_active)
    else $error("raised set before arming delay");
  AST_REENERGIZE: assert property (s_armed_ok |-> s_reenergize // RULE_05
      or (deen ##1 state_q == CLP_ARMED))
    else $error("re-energize did not start active timer");
  AST_ACT_EXPIRE: assert property (state_q == CLP_ACTIVE && run_ok // RULE_06
      && !deen && act_done && !i_elem_pickup |=> !o_raised_active)
    else $error("active expiry did not restore normal set");
  AST_STOP_EXPIRE: assert property (state_q == CLP_ACTIVE && run_ok // RULE_07
      && !deen && stop_done && !i_elem_pickup |=> state_q == CLP_IDLE)
    else $error("quiet expiry did not restore normal set");
  AST_STOP_DEFEAT: assert property (state_q == CLP_ACTIVE && run_ok // RULE_08
      && stop_off && !act_done |=> o_raised_active)
    else $error("defeated quiet timer restored normal set");
  AST_HOLD_PICKUP: assert property (o_raised_active && run_ok // RULE_09
      && i_elem_pickup && !deen |=> o_raised_active)
    else $error("normal set restored during pickup");
  AST_BLOCK: assert property (blk |=> !o_raised_active // RULE_10
      && arm_cnt_q == '0 && act_cnt_q == '0 && stop_cnt_q == '0)
    else $error("block did not clear timers");
  AST_RESTART: assert property (blk && !blk_d_q && raised // RULE_11
      && i_elem_pickup |=> o_elem_restart ##1 !o_elem_restart)
    else $error("element timers not restarted on block");
  AST_PRESENT: assert property (!present_q |=> state_q == CLP_IDLE) // RULE_13
    else $error("feature ran while not present");
endmodule // clp_switch

//--- rtl/clp_pkg.sv
// package: constants for the cold load threshold switch
package clp_pkg;
  localparam int DW = 16; // register and parameter data width
  localparam int AW = 12; // register address width
  localparam int TW = 15; // seconds counter width
  // time base
  localparam int SEC_NS = 1000000000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_CYCLES = SEC_NS / CLK_PERIOD_NS;
  // register addresses
  localparam logic [AW-1:0] A_PRESENT = 12'h075;
  localparam logic [AW-1:0] A_ENABLE = 12'h6a5;
  localparam logic [AW-1:0] A_SOURCE = 12'h6a6;
  localparam logic [AW-1:0] A_ARMING = 12'h6a7;
  localparam logic [AW-1:0] A_ACTIVE = 12'h6a8;
  localparam logic [AW-1:0] A_STOP = 12'h6a9;
  localparam logic [AW-1:0] A_PHASE_BASE = 12'h709;
  localparam logic [AW-1:0] A_GROUND_BASE = 12'h76d;
  localparam logic [AW-1:0] A_STATUS = 12'h0f0;
  localparam int N_PER_SET = 7;
  localparam int N_PARAM = 16;
  localparam logic [3:0] GROUND_IDX0 = 4'h8;
  // field positions
  localparam int F_BIT0 = 0;
  localparam int F_STAT_RAISED = 0;
  localparam int F_STAT_STATE = 1;
  localparam int F_STAT_DEEN = 4;
  localparam int F_STAT_ON = 5;
  // reset values
  localparam logic RST_PRESENT = 1'b0;
  localparam logic RST_ENABLE = 1'b0;
  localparam logic RST_SOURCE = 1'b0; // 0: no current, 1: breaker
  localparam logic [TW-1:0] RST_ARMING = 15'h0e10; // 3600 s
  localparam logic [TW-1:0] RST_ACTIVE = 15'h0e10; // 3600 s
  localparam logic [TW-1:0] RST_STOP = 15'h0258; // 600 s, 0 = infinite
  localparam logic [TW-1:0] MAX_ARMING = 15'h5460; // 21600 s
  localparam logic [TW-1:0] MAX_ACTIVE = 15'h5460;
  localparam logic [TW-1:0] MAX_STOP = 15'h0258;
  localparam logic [TW-1:0] MIN_ACTIVE = 15'h0001;
  // raised set defaults in hundredths: phase 0..6, ground 8..14
  localparam logic [DW-1:0] RST_RAISED [N_PARAM] = '{
    16'h1388, 16'h0000, 16'h03e8, 16'h001e, 16'h02ee, 16'h0032,
    16'h01f4, 16'h0000, 16'h0dac, 16'h0000, 16'h02ee, 16'h001e,
    16'h01f4, 16'h0032, 16'h01f4, 16'h0000};
  typedef enum logic [2:0] {
    CLP_IDLE   = 3'b000,
    CLP_ARMING = 3'b001,
    CLP_ARMED  = 3'b010,
    CLP_ACTIVE = 3'b011,
    CLP_HOLD   = 3'b100
  } clp_state_e;
endpackage

//--- rtl/clp_param_mem.sv
// raised parameter store with two registered read ports
`timescale 1ns/1ns
module clp_param_mem
  import clp_pkg::*;
(
  input  wire logic          i_clk_sys,
  input  wire logic          i_arst_n,
  input  wire logic          i_we,
  input  wire logic [3:0]    i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  input  wire logic [3:0]    i_raddr_a,
  output logic      [DW-1:0] o_rdata_a,
  input  wire logic [3:0]    i_raddr_b,
  output logic      [DW-1:0] o_rdata_b
);
  logic [DW-1:0] mem_q [N_PARAM];

  // small store, so it is reset to the documented defaults
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mem_q <= RST_RAISED;
    end else if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
  end

  // read data come out of registers
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata_a <= '0;
      o_rdata_b <= '0;
    end else begin
      o_rdata_a <= mem_q[i_raddr_a];
      o_rdata_b <= mem_q[i_raddr_b];
    end
  end
endmodule // clp_param_mem

//--- testbench/clp_field_model.sv
// field side model: breaker contact, current monitor, overcurrent elements
`timescale 1ns/1ns
module clp_field_model #(
  parameter int P_LAG = 8
) (
  input  wire logic i_clk_sys,
  input  wire logic i_energized,
  input  wire logic i_slow,
  input  wire logic i_fault,
  output logic      o_brk_closed,
  output logic      o_cur_flow,
  output logic      o_below_normal,
  output logic      o_elem_pickup
);
  logic brk_q = 1'b1;
  int   lag_q = 0;
  // a slow breaker contact trails the primary switching by P_LAG cycles
  always_ff @(posedge i_clk_sys) begin
    lag_q <= (i_energized == brk_q) ? 0 : lag_q + 1;
    if (i_energized != brk_q && (!i_slow || lag_q >= P_LAG))
      brk_q <= i_energized;
  end
  // current follows the primary at once; a fault lifts it above pickups
  assign o_brk_closed   = brk_q;
  assign o_cur_flow     = i_energized;
  assign o_below_normal = !i_fault;
  assign o_elem_pickup  = i_fault & i_energized;
endmodule // clp_field_model

//--- testbench/clp_switch_test.sv
// self-checking bench for the cold load threshold switch
`timescale 1ns/1ns
module clp_switch_test;
  import clp_pkg::*;
  localparam int TK = 4; // short tick: one second is four cycles
  logic          clk, rst_n, wr, rd, blk, sblk, en, slow, flt;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata, rdata, eparam;
  logic [3:0]    idx;
  logic          brk, cur, below, pick, raised, restart;
  int            num_errors = 0;
  int            check_count = 0;
  // address beside expected reset data; last row is unmapped
  logic [27:0]   rows [12] = '{
    {A_PRESENT, 16'h0000}, {A_ENABLE, 16'h0000}, {A_SOURCE, 16'h0000},
    {A_ARMING, 16'h0e10}, {A_ACTIVE, 16'h0e10}, {A_STOP, 16'h0258},
    {12'h709, 16'h1388}, {12'h70c, 16'h001e}, {12'h70f, 16'h01f4},
    {12'h76d, 16'h0dac}, {12'h773, 16'h01f4}, {12'h123, 16'h0000}};

  clp_switch #(.P_TICK_CYCLES(TK)) u_dut (
    .i_clk_sys(clk), .i_arst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_brk_closed(brk),
    .i_cur_flow(cur), .i_below_normal(below), .i_block(blk),
    .i_stop_block(sblk), .i_elem_pickup(pick), .i_elem_idx(idx),
    .o_elem_param(eparam), .o_raised_active(raised),
    .o_elem_restart(restart));
  clp_field_model u_field (
    .i_clk_sys(clk), .i_energized(en), .i_slow(slow), .i_fault(flt),
    .o_brk_closed(brk), .o_cur_flow(cur), .o_below_normal(below),
    .o_elem_pickup(pick));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk16(input string nm, input logic [DW-1:0] e,
                       input logic [DW-1:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // a gap edge after each write so wr is never assigned twice at once
  task automatic wreg(input logic [AW-1:0] a, input logic [DW-1:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rreg(input logic [AW-1:0] a, input logic [DW-1:0] e);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk16("rdata", e, rdata);
    @(posedge clk);
  endtask

  task automatic pchk(input logic [3:0] i, input logic [DW-1:0] e);
    idx <= i;
    @(posedge clk);
    @(negedge clk);
    chk16("elem_param", e, eparam);
    @(posedge clk);
  endtask

  // bounded wait for the raised status to reach a level
  task automatic wait_for(input logic e, input int n);
    int i;
    i = 0;
    @(negedge clk);
    while (raised !== e && i < n) begin
      @(negedge clk);
      i++;
    end
    chk1("raised_active", e, raised);
    @(posedge clk);
  endtask

  task automatic hold(input logic e, input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
    chk1("raised_active", e, raised);
    @(posedge clk);
  endtask

  initial begin
    #(4000 * 50);
    num_errors++;
    stop_test();
  end

  initial begin
    int k;
    rst_n = 1'b0; wr = 1'b0; rd = 1'b0; blk = 1'b0; sblk = 1'b0;
    en = 1'b1; slow = 1'b0; flt = 1'b0; addr = '0; wdata = '0; idx = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      rreg(rows[i][27:16], rows[i][15:0]);
    end
    en <= 1'b0;
    hold(1'b0, 20);
    wreg(A_ENABLE, 16'h0001);
    hold(1'b0, 20);
    wreg(A_ARMING, 16'h7fff);
    rreg(A_ARMING, 16'h5460);
    wreg(A_ACTIVE, 16'h0000);
    rreg(A_ACTIVE, 16'h0001);
    wreg(A_ARMING, 16'h0002);
    wreg(A_ACTIVE, 16'h0003);
    wreg(A_STOP, 16'h0000);
    wreg(A_PRESENT, 16'h0001);
    hold(1'b0, 3);
    wait_for(1'b1, 16);
    en <= 1'b1;
    hold(1'b1, 4);
    wait_for(1'b0, 20);
    // quiet timer of one second against a long active hold
    wreg(A_ACTIVE, 16'h0028);
    wreg(A_STOP, 16'h0001);
    en <= 1'b0;
    wait_for(1'b1, 20);
    en <= 1'b1;
    wait_for(1'b0, 12);
    sblk <= 1'b1;
    en   <= 1'b0;
    wait_for(1'b1, 20);
    en <= 1'b1;
    hold(1'b1, 20);
    sblk <= 1'b0;
    wait_for(1'b0, 12);
    // element picked up during re-energizing defers the release
    wreg(A_ACTIVE, 16'h0001);
    flt <= 1'b1;
    en  <= 1'b0;
    wait_for(1'b1, 20);
    en <= 1'b1;
    hold(1'b1, 20);
    flt <= 1'b0;
    wait_for(1'b0, 6);
    // block in mid-fault on the raised set
    wreg(A_ACTIVE, 16'h0028);
    flt <= 1'b1;
    en  <= 1'b0;
    wait_for(1'b1, 20);
    en <= 1'b1;
    repeat (2) @(posedge clk);
    blk <= 1'b1;
    k = 0;
    @(negedge clk);
    while (restart !== 1'b1 && k < 6) begin
      @(negedge clk);
      k++;
    end
    chk1("elem_restart", 1'b1, restart);
    @(posedge clk);
    wait_for(1'b0, 4);
    blk <= 1'b0;
    flt <= 1'b0;
    // breaker contact source with a slow contact
    wreg(A_ACTIVE, 16'h0003);
    wreg(A_SOURCE, 16'h0001);
    slow <= 1'b1;
    en   <= 1'b0;
    wait_for(1'b1, 30);
    en <= 1'b1;
    hold(1'b1, 6);
    wait_for(1'b0, 30);
    pchk(4'h8, 16'h0dac);
    wreg(12'h70b, 16'h0123);
    pchk(4'h2, 16'h0123);
    rreg(12'h70b, 16'h0123);
    wreg(A_STATUS, 16'hffff);
    rreg(A_STATUS, 16'h0020);
    // reset in mid-run with the breaker already open
    slow  <= 1'b0;
    en    <= 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rreg(A_ENABLE, 16'h0000);
    rreg(A_SOURCE, 16'h0000);
    rreg(A_STATUS, 16'h0010);
    // open breaker at power-up arms on the normal set; closing keeps it
    wreg(A_SOURCE, 16'h0001);
    wreg(A_ENABLE, 16'h0001);
    wreg(A_PRESENT, 16'h0001);
    rreg(A_STATUS, 16'h0032);
    en <= 1'b1;
    hold(1'b0, 8);
    rreg(A_STATUS, 16'h0020);
    stop_test();
  end
endmodule // clp_switch_test
